// [logic/clp_port.sv]
// Configuration load port: parallel and serial intake, pacing, daisy-chain and init status line
`timescale 1ns/10ps
`include "clp_regs.svh"
module clp_port #(
  parameter int WIDTH = `CLP_BYTE_WIDTH,
  parameter int DEPTH = `CLP_FIFO_DEPTH,
  parameter int CLEAR_CYCLES = `CLP_CLEAR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mode_parallel,
  input wire logic retain_port,
  input wire logic port_sel_n,
  input wire logic write_n_read,
  input wire logic serial_strobe,
  input wire logic [WIDTH-1:0] cfg_byte_lines_in,
  output logic [WIDTH-1:0] cfg_byte_lines_out,
  output logic cfg_byte_lines_oe,
  output logic pace_dout_out,
  output logic pace_dout_oe,
  input wire logic init_status_in,
  output logic init_status_out,
  output logic init_status_oe,
  input wire logic cfg_error,
  input wire logic cfg_end,
  input wire logic [WIDTH-1:0] readback_byte,
  output logic [WIDTH-1:0] cfg_word,
  output logic cfg_word_valid,
  input wire logic cfg_word_ready,
  output logic cfg_active,
  output logic cfg_failed
);
  localparam int LW = $clog2(DEPTH + 1);
  localparam int CW = $clog2(CLEAR_CYCLES + 1);

  clp_stream_if #(.WIDTH(WIDTH), .DEPTH(DEPTH)) st ();

  clp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .st(st.buffer)
  );

  clp_pkg::clp_state_e state;
  clp_pkg::clp_state_e next_state;
  logic [CW-1:0] clear_cnt;
  logic [CW-1:0] next_clear_cnt;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [WIDTH-1:0] shreg;
  logic [WIDTH-1:0] next_shreg;
  logic error;
  logic next_error;
  logic retain;
  logic next_retain;
  logic next_pace_dout_out;
  logic next_pace_dout_oe;
  logic [WIDTH-1:0] next_cfg_byte_lines_out;
  logic next_cfg_byte_lines_oe;
  logic next_init_status_oe;
  logic next_cfg_active;
  logic port_live;
  logic par_wr;
  logic par_rd;
  logic ser_bit;
  logic ser_push;
  logic [LW:0] fill_next;

  // Port access decode and the byte stream into the buffer
  assign port_live = (state == clp_pkg::CLP_LOAD) || (state == clp_pkg::CLP_USER && retain);
  assign par_wr = mode_parallel && port_live && !port_sel_n && !write_n_read;
  assign par_rd = mode_parallel && state == clp_pkg::CLP_USER && retain && !port_sel_n && write_n_read;
  assign ser_bit = !mode_parallel && state == clp_pkg::CLP_LOAD && serial_strobe && !error;
  assign ser_push = ser_bit && (bit_cnt == `CLP_BIT_LAST);
  assign st.in_valid = par_wr || ser_push;
  assign st.in_data = mode_parallel ? cfg_byte_lines_in : {shreg[WIDTH-2:0], cfg_byte_lines_in[`CLP_SERIAL_BIT]};
  assign st.out_ready = cfg_word_ready;
  assign cfg_word = st.out_data;
  assign cfg_word_valid = st.out_valid;
  assign init_status_out = 1'b0;
  assign cfg_failed = error;

  // Buffer fill after this cycle, used to raise pacing before the buffer overflows
  assign fill_next = (LW + 1)'(st.level) + (LW + 1)'(st.in_valid && st.in_ready)
    - (LW + 1)'(st.out_valid && st.out_ready);

  // Sequencer: clear, wait for release, load, then user mode
  always_comb begin
    next_state = state;
    next_clear_cnt = clear_cnt;
    next_retain = retain;
    unique case (state)
      clp_pkg::CLP_CLEAR: begin
        if (clear_cnt == CW'(CLEAR_CYCLES - 1)) begin
          next_state = clp_pkg::CLP_WAIT;
        end else begin
          next_clear_cnt = clear_cnt + CW'(1);
        end
      end
      clp_pkg::CLP_WAIT: begin
        if (init_status_in) begin
          next_state = clp_pkg::CLP_LOAD;
        end
      end
      clp_pkg::CLP_LOAD: begin
        if (cfg_end && !error) begin
          next_state = clp_pkg::CLP_USER;
          next_retain = retain_port;
        end
      end
      clp_pkg::CLP_USER: begin
        next_state = clp_pkg::CLP_USER;
      end
    endcase
  end

  // Serial deserialiser and error capture
  always_comb begin
    next_shreg = shreg;
    next_bit_cnt = bit_cnt;
    next_error = error;
    if (ser_bit) begin
      next_shreg = {shreg[WIDTH-2:0], cfg_byte_lines_in[`CLP_SERIAL_BIT]};
      next_bit_cnt = bit_cnt + 3'h1;
    end
    if (state == clp_pkg::CLP_LOAD && (cfg_error || (ser_push && !st.in_ready))) begin
      next_error = 1'b1;
    end
  end

  // Pin drivers: pacing or serial-out, data readback, init status
  always_comb begin
    next_pace_dout_out = pace_dout_out;
    next_pace_dout_oe = 1'b0;
    next_cfg_byte_lines_out = cfg_byte_lines_out;
    next_cfg_byte_lines_oe = 1'b0;
    next_init_status_oe = 1'b0;
    next_cfg_active = (next_state != clp_pkg::CLP_USER);
    if (mode_parallel) begin
      next_pace_dout_out = (fill_next >= (LW + 1)'(DEPTH));
    end else if (ser_bit) begin
      next_pace_dout_out = cfg_byte_lines_in[`CLP_SERIAL_BIT];
    end
    if (next_state == clp_pkg::CLP_LOAD) begin
      next_pace_dout_oe = 1'b1;
    end else if (next_state == clp_pkg::CLP_USER) begin
      next_pace_dout_oe = next_retain && mode_parallel;
    end
    if (par_rd) begin
      next_cfg_byte_lines_out = readback_byte;
      next_cfg_byte_lines_oe = 1'b1;
    end
    if (next_state == clp_pkg::CLP_CLEAR) begin
      next_init_status_oe = 1'b1;
    end else if (next_state == clp_pkg::CLP_LOAD) begin
      next_init_status_oe = next_error;
    end
  end

  // State registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= clp_pkg::CLP_CLEAR;
      clear_cnt <= '0;
      bit_cnt <= 3'h0;
      shreg <= '0;
      error <= 1'b0;
      retain <= 1'b0;
      pace_dout_out <= 1'b0;
      pace_dout_oe <= 1'b0;
      cfg_byte_lines_out <= '0;
      cfg_byte_lines_oe <= 1'b0;
      init_status_oe <= 1'b1;
      cfg_active <= 1'b1;
    end else begin
      state <= next_state;
      clear_cnt <= next_clear_cnt;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      error <= next_error;
      retain <= next_retain;
      pace_dout_out <= next_pace_dout_out;
      pace_dout_oe <= next_pace_dout_oe;
      cfg_byte_lines_out <= next_cfg_byte_lines_out;
      cfg_byte_lines_oe <= next_cfg_byte_lines_oe;
      init_status_oe <= next_init_status_oe;
      cfg_active <= next_cfg_active;
    end
  end

  // Checks on the sequencer and pin behaviour
  sequence s_par_write;
    mode_parallel && state == clp_pkg::CLP_LOAD && !port_sel_n && !write_n_read && !pace_dout_out;
  endsequence

  sequence s_ser_bit;
    !mode_parallel && state == clp_pkg::CLP_LOAD && serial_strobe && !error;
  endsequence

  sequence s_released;
    state == clp_pkg::CLP_WAIT && init_status_in;
  endsequence

  a_par_write_take: assert property (@(posedge clk_sys) disable iff (reset)
    s_par_write |-> st.in_valid && st.in_ready && st.in_data == cfg_byte_lines_in)
    else $error("parallel write not taken into buffer");

  a_sel_gate: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_parallel && port_sel_n) |-> !st.in_valid ##1 !cfg_byte_lines_oe)
    else $error("port acted while not selected");

  a_read_no_push: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_parallel && write_n_read) |-> !st.in_valid)
    else $error("read request treated as a write");

  a_pace_room: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_parallel && !pace_dout_out) |-> st.in_ready)
    else $error("pacing released with no room in buffer");

  a_serial_forward: assert property (@(posedge clk_sys) disable iff (reset)
    s_ser_bit |=> pace_dout_out == $past(cfg_byte_lines_in[0]) && pace_dout_oe)
    else $error("serial bit not forwarded downstream");

  a_user_release: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_USER && !retain) |-> !pace_dout_oe && !cfg_byte_lines_oe)
    else $error("port pins driven after configuration without retention");

  a_data_input: assert property (@(posedge clk_sys) disable iff (reset)
    (state != clp_pkg::CLP_USER) |-> !cfg_byte_lines_oe)
    else $error("data lines driven during configuration");

  a_pace_drive: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_LOAD) |-> pace_dout_oe)
    else $error("pacing pin not driven during load");

  a_clear_low: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_CLEAR) |-> init_status_oe && !init_status_out)
    else $error("init line not held low while clearing");

  a_hold_off: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_WAIT && !init_status_in) |=> state == clp_pkg::CLP_WAIT)
    else $error("configuration started while init line held low");

  a_release_high: assert property (@(posedge clk_sys) disable iff (reset)
    s_released |=> state == clp_pkg::CLP_LOAD && !init_status_oe)
    else $error("init line not released after clearing");

  a_error_low: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_LOAD && cfg_error) |=> init_status_oe [*2])
    else $error("data error did not pull init line low");

  a_user_init: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_USER) |-> !init_status_oe)
    else $error("init line driven after configuration");

  a_clear_length: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(state == clp_pkg::CLP_WAIT) |-> $past(clear_cnt) == CW'(CLEAR_CYCLES - 1))
    else $error("clearing period has wrong length");

  // Checks on pacing, readback, error reporting and the end of configuration
  a_busy_full: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_parallel && !st.in_ready) |-> pace_dout_out)
    else $error("pacing not busy while buffer full");

  a_read_answer: assert property (@(posedge clk_sys) disable iff (reset)
    (mode_parallel && state == clp_pkg::CLP_USER && retain && !port_sel_n && write_n_read)
    |=> cfg_byte_lines_oe && cfg_byte_lines_out == $past(readback_byte))
    else $error("read request not answered on data lines");

  a_overflow_error: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_LOAD && ser_push && !st.in_ready && !cfg_end) |=> error && init_status_oe)
    else $error("serial overflow not reported on init line");

  a_error_sticky: assert property (@(posedge clk_sys) disable iff (reset)
    error |=> error)
    else $error("error flag cleared without reset");

  a_wait_released: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_WAIT) |-> !init_status_oe)
    else $error("init line pulled low after clearing ended");

  a_user_inactive: assert property (@(posedge clk_sys) disable iff (reset)
    (state == clp_pkg::CLP_USER) |-> !cfg_active)
    else $error("configuration still flagged active in user mode");
endmodule

// [logic/clp_regs.svh]
// Timing counts, widths and field positions of the configuration load port
`ifndef CLP_REGS_SVH
`define CLP_REGS_SVH

`define CLP_CLK_PERIOD_NS 100
`define CLP_CLEAR_TIME_NS 2000
`define CLP_CLEAR_CYCLES ((`CLP_CLEAR_TIME_NS + `CLP_CLK_PERIOD_NS - 1) / `CLP_CLK_PERIOD_NS)
`define CLP_BYTE_WIDTH 8
`define CLP_FIFO_DEPTH 4
`define CLP_SERIAL_BIT 0
`define CLP_BIT_LAST 3'h7

`endif

// [logic/clp_pkg.sv]
// Types shared by the configuration load port modules
package clp_pkg;

  typedef enum logic [1:0] {
    CLP_CLEAR = 2'b00,
    CLP_WAIT = 2'b01,
    CLP_LOAD = 2'b10,
    CLP_USER = 2'b11
  } clp_state_e;

  typedef logic [7:0] clp_byte_t;

endpackage

// [logic/clp_stream_if.sv]
// Valid/ready byte stream between the port logic and its buffer
`timescale 1ns/10ps
interface clp_stream_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
);
  localparam int LW = $clog2(DEPTH + 1);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [LW-1:0] level;

  modport buffer (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, level
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, level
  );
endinterface

// [logic/clp_fifo.sv]
// Small synchronous FIFO holding configuration bytes
`timescale 1ns/10ps
module clp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic reset,
  clp_stream_if.buffer st
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [LW-1:0] count;
  logic [AW-1:0] next_wptr;
  logic [AW-1:0] next_rptr;
  logic [LW-1:0] next_count;
  logic push;
  logic pop;

  // Handshake terms and flags
  assign push = st.in_valid && st.in_ready;
  assign pop = st.out_valid && st.out_ready;
  assign st.in_ready = (count != LW'(DEPTH));
  assign st.out_valid = (count != '0);
  assign st.out_data = mem[rptr];
  assign st.level = count;

  // Pointer and fill arithmetic with wrap at DEPTH
  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    if (push) begin
      next_wptr = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
    end
    if (pop) begin
      next_rptr = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
    end
    next_count = count + LW'(push) - LW'(pop);
  end

  // State registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // Storage, written only on an accepted push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr] <= st.in_data;
    end
  end
endmodule

// [dv/clp_host_model.sv]
// Host model driving the configuration load port: parallel writer, serial source, init line holder
`timescale 1ns/10ps
module clp_host_model (
  input wire logic clk_sys,
  input wire logic pace_dout_out,
  input wire logic init_status_oe,
  output logic port_sel_n,
  output logic write_n_read,
  output logic serial_strobe,
  output logic [7:0] cfg_byte_lines_in,
  output logic init_status_in
);
  logic hold_init = 1'b0;
  int stall_cnt = 0;
  // Wired line with pull-up: low while either party pulls it
  assign init_status_in = ~(init_status_oe | hold_init);
  initial begin
    port_sel_n = 1'b1;
    write_n_read = 1'b0;
    serial_strobe = 1'b0;
    cfg_byte_lines_in = 8'hFF;
  end
  // One parallel cycle, entered and left at a falling edge; released lines show the inverse
  task automatic drive(input logic [7:0] b, input logic rd, input logic sel_n);
    int n;
    n = 0;
    while (pace_dout_out === 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 50) stall_cnt++;
    port_sel_n = sel_n;
    write_n_read = rd;
    cfg_byte_lines_in = b;
    @(negedge clk_sys);
    port_sel_n = 1'b1;
    cfg_byte_lines_in = ~b;
    @(negedge clk_sys);
  endtask
  // One serial bit on data line 0 with a strobe, then an idle cycle
  task automatic send_bit(input logic b);
    cfg_byte_lines_in = {7'h00, b};
    serial_strobe = 1'b1;
    @(negedge clk_sys);
    serial_strobe = 1'b0;
    cfg_byte_lines_in = {7'h7F, ~b};
    @(negedge clk_sys);
  endtask
endmodule

// [dv/config_load_port_test.sv]
// Self-checking testbench of the configuration load port
`timescale 1ns/10ps
module config_load_port_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic mode_parallel = 1'b1;
  logic retain_port = 1'b0;
  logic cfg_error = 1'b0;
  logic cfg_end = 1'b0;
  logic cfg_word_ready = 1'b0;
  logic [7:0] readback_byte = 8'h00;
  logic port_sel_n, write_n_read, serial_strobe, init_status_in;
  logic [7:0] cfg_byte_lines_in, cfg_byte_lines_out, cfg_word;
  logic cfg_byte_lines_oe, pace_dout_out, pace_dout_oe, init_status_out, init_status_oe;
  logic cfg_word_valid, cfg_active, cfg_failed;
  int error_cnt = 0;
  int total_checks = 0;

  clp_port #(.CLEAR_CYCLES(2)) dut_u (.clk_sys(clk_sys), .reset(reset), .mode_parallel(mode_parallel),
    .retain_port(retain_port), .port_sel_n(port_sel_n), .write_n_read(write_n_read),
    .serial_strobe(serial_strobe), .cfg_byte_lines_in(cfg_byte_lines_in),
    .cfg_byte_lines_out(cfg_byte_lines_out), .cfg_byte_lines_oe(cfg_byte_lines_oe),
    .pace_dout_out(pace_dout_out), .pace_dout_oe(pace_dout_oe), .init_status_in(init_status_in),
    .init_status_out(init_status_out), .init_status_oe(init_status_oe), .cfg_error(cfg_error),
    .cfg_end(cfg_end), .readback_byte(readback_byte), .cfg_word(cfg_word),
    .cfg_word_valid(cfg_word_valid), .cfg_word_ready(cfg_word_ready), .cfg_active(cfg_active),
    .cfg_failed(cfg_failed));

  clp_host_model host_u (.clk_sys(clk_sys), .pace_dout_out(pace_dout_out), .init_status_oe(init_status_oe),
    .port_sel_n(port_sel_n), .write_n_read(write_n_read), .serial_strobe(serial_strobe),
    .cfg_byte_lines_in(cfg_byte_lines_in), .init_status_in(init_status_in));

  // 10 MHz system clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    error_cnt += host_u.stall_cnt;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Reset held for 12 cycles with the chosen intake mode
  task automatic do_reset(input logic par);
    @(negedge clk_sys);
    reset = 1'b1;
    mode_parallel = par;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
  endtask

  // Bounded wait for the load phase, then one settled cycle
  task automatic wait_load();
    int n;
    n = 0;
    while (init_status_oe !== 1'b0 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 40) begin
      error_cnt++;
      test_done();
    end
    @(negedge clk_sys);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Clearing holds the line low; an outside hold postpones the start
  task automatic s_startup();
    host_u.hold_init = 1'b1;
    do_reset(1'b1);
    chk_bit("init_oe clearing", 1'b1, init_status_oe);
    chk_bit("init out level", 1'b0, init_status_out);
    repeat (10) @(negedge clk_sys);
    chk_bit("pace_oe held", 1'b0, pace_dout_oe);
    chk_bit("init line held", 1'b0, init_status_in);
    host_u.hold_init = 1'b0;
    wait_load();
    chk_bit("init line high", 1'b1, init_status_in);
    chk_bit("pace_oe load", 1'b1, pace_dout_oe);
  endtask

  // Refused cycles, fill to busy, then drain in order
  task automatic s_parallel_fill();
    cfg_word_ready = 1'b0;
    host_u.drive(8'h5A, 1'b0, 1'b1);
    chk_bit("valid unselected", 1'b0, cfg_word_valid);
    host_u.drive(8'hC3, 1'b1, 1'b0);
    chk_bit("valid on read", 1'b0, cfg_word_valid);
    chk_bit("data oe config", 1'b0, cfg_byte_lines_oe);
    for (int i = 0; i < 4; i++) host_u.drive(8'hA0 + 8'(i), 1'b0, 1'b0);
    chk_bit("busy full", 1'b1, pace_dout_out);
    chk_byte("head byte", 8'hA0, cfg_word);
    cfg_word_ready = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk_byte("drain byte", 8'hA0 + 8'(i), cfg_word);
      @(negedge clk_sys);
    end
    cfg_word_ready = 1'b0;
    @(negedge clk_sys);
    chk_bit("empty", 1'b0, cfg_word_valid);
    chk_bit("busy free", 1'b0, pace_dout_out);
  endtask

  task automatic s_error();
    pulse(cfg_error);
    chk_bit("init_oe error", 1'b1, init_status_oe);
    chk_bit("failed flag", 1'b1, cfg_failed);
  endtask

  // Serial byte, most significant bit first, each bit forwarded
  task automatic s_serial();
    logic [7:0] v;
    v = 8'hB4;
    do_reset(1'b0);
    wait_load();
    for (int i = 7; i >= 0; i--) begin
      host_u.send_bit(v[i]);
      chk_bit("forwarded bit", v[i], pace_dout_out);
    end
    chk_byte("serial byte", v, cfg_word);
    chk_bit("serial valid", 1'b1, cfg_word_valid);
    // Four more bytes with no drain: the fifth push finds the buffer full
    for (int k = 0; k < 4; k++) begin
      for (int i = 7; i >= 0; i--) host_u.send_bit(v[i]);
    end
    chk_bit("overflow failed", 1'b1, cfg_failed);
    chk_bit("init_oe overflow", 1'b1, init_status_oe);
  endtask

  // End of configuration with and without port retention
  task automatic s_end(input logic keep);
    do_reset(1'b1);
    wait_load();
    retain_port = keep;
    readback_byte = 8'h3C;
    pulse(cfg_end);
    chk_bit("active end", 1'b0, cfg_active);
    chk_bit("init_oe user", 1'b0, init_status_oe);
    chk_bit("pace_oe user", keep, pace_dout_oe);
    host_u.drive(8'h00, 1'b1, 1'b0);
    chk_bit("data oe user", 1'b0, cfg_byte_lines_oe);
    host_u.hold_init = 1'b0;
    if (keep) begin
      host_u.port_sel_n = 1'b0;
      host_u.write_n_read = 1'b1;
      @(negedge clk_sys);
      chk_bit("read oe", 1'b1, cfg_byte_lines_oe);
      chk_byte("read data", 8'h3C, cfg_byte_lines_out);
      host_u.port_sel_n = 1'b1;
    end
    retain_port = 1'b0;
  endtask

  initial begin
    s_startup();
    s_parallel_fill();
    s_error();
    s_serial();
    s_end(1'b1);
    s_end(1'b0);
    test_done();
  end
endmodule
